// ---- src/lp3t_top.sv ----
`timescale 1ns/100ps
//
// Contract
// R1: wait 20 cycles after training entry write
// R2: hold CKE high 10 cycles after entry
// R3: wait 10 cycles after CKE low
// R4: calibration result on DQ within 20 ns; the design takes one 25 ns mclk cycle after the command edge
// R5: space calibration commands by output delay
// R6: keep CKE low 10 cycles after result
// R7: wait 10 cycles after CKE high to exit
// R8: drive DQ 3 ns past exit, then release
// R9: leveling feedback on DQ within 20 ns; the design takes one 25 ns mclk cycle after the sampled strobe rise
// R10: wait 25 cycles before strobe drivers
// R11: termination follows ODT pin within 3.5 ns; the design takes at least one 25 ns mclk cycle
// R12: termination off within 12 ns, power entry; the design takes two mclk cycles (50 ns)
// R13: termination on within 12 ns, power exit; the design takes two mclk cycles (50 ns)
// R14: derated activate to read adds 1.875 ns
// R15: derated precharge adds 1.875 ns
// R16: derated activate spacing adds 1.875 ns
// R17: reset write loads defaults into subset
// R18: controller rounds nanosecond minimums up
module lp3t_top #(
    parameter int DQ_W = 32
) (
    input  wire logic                      mclk,
    input  wire logic                      srst,
    input  wire logic                      cke,
    input  wire lp3t_pkg::lp3t_cmd_t       cmd,
    input  wire logic [7:0]                mr_addr,
    input  wire logic [lp3t_pkg::MR_W-1:0] mr_data,
    input  wire logic [lp3t_pkg::CA_W-1:0] ca_cal,
    input  wire logic                      dqs,
    input  wire logic                      ck_level,
    input  wire logic                      odt,
    output logic      [DQ_W-1:0]           dq_o,
    output logic                           dq_oe,
    output logic                           rtt_en,
    output logic                           train_active,
    output logic                           wrlvl_active,
    output logic                           low_power,
    output logic      [3*lp3t_pkg::MR_W-1:0] mr_cfg
);
    import lp3t_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    lp3t_state_t     st_r,    st_nxt;
    logic [MR_W-1:0] mr1_r,   mr1_nxt;
    logic [MR_W-1:0] mr2_r,   mr2_nxt;
    logic [MR_W-1:0] mr3_r,   mr3_nxt;
    logic [DQ_W-1:0] dq_r,    dq_nxt;
    logic            oe_r,    oe_nxt;
    logic            cke_r,   cke_nxt;
    logic            dqs_r,   dqs_nxt;
    logic            lp_r,    lp_nxt;
    logic            smp_r,   smp_nxt;
    logic            tgt_r,   tgt_nxt;
    logic            rtt_r,   rtt_nxt;
    logic            is_mrw, cal_go, exit_go, wl_edge, rtt_want, rtt_go;
    logic            adr_fire, mrz_fire, wlo_fire, rtt_fire;

    ////////////////////////////////////////////////////////////////////////
    // decode of the incoming command
    assign is_mrw   = (cmd == CMD_MRW);
    assign cal_go   = (cmd == CMD_CAL) && (st_r == ST_CAT);
    assign exit_go  = is_mrw && (mr_addr == MRA_CAT_EXIT) && (st_r == ST_CAT);
    assign wl_edge  = dqs && !dqs_r && mr2_r[WRLVL_BIT]
                      && (st_r == ST_IDLE);
    assign rtt_want = odt && !lp_r;
    assign rtt_go   = (rtt_want != tgt_r);

    // output delay timers
    lp3t_dly #(.CYC(ADR_CYC)) u_adr (
        .mclk  (mclk),
        .srst  (srst),
        .start (cal_go),
        .fire  (adr_fire)
    );
    lp3t_dly #(.CYC(MRZ_CYC)) u_mrz (
        .mclk  (mclk),
        .srst  (srst),
        .start (exit_go),
        .fire  (mrz_fire)
    );
    lp3t_dly #(.CYC(WLO_CYC)) u_wlo (
        .mclk  (mclk),
        .srst  (srst),
        .start (wl_edge),
        .fire  (wlo_fire)
    );
    lp3t_dly #(.CYC(RTT_CYC)) u_rtt (
        .mclk  (mclk),
        .srst  (srst),
        .start (rtt_go),
        .fire  (rtt_fire)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state of training, mode registers, data pins and termination
    always_comb begin
        st_nxt  = st_r;
        mr1_nxt = mr1_r;
        mr2_nxt = mr2_r;
        mr3_nxt = mr3_r;
        dq_nxt  = dq_r;
        oe_nxt  = oe_r;
        cke_nxt = cke;
        dqs_nxt = dqs;
        lp_nxt  = lp_r;
        smp_nxt = smp_r;
        tgt_nxt = tgt_r;
        rtt_nxt = rtt_r;
        // mode register writes
        if (is_mrw) begin
            unique case (mr_addr)
                MRA_CFG1:      mr1_nxt = mr_data;
                MRA_CFG2:      mr2_nxt = mr_data;
                MRA_CFG3:      mr3_nxt = mr_data;
                MRA_RESET: begin
                    mr1_nxt = MR1_DEF;                  // [R17]
                    mr2_nxt = MR2_DEF;                  // [R17]
                end
                MRA_CAT_ENTRY: begin
                    if (st_r == ST_IDLE) begin
                        st_nxt = ST_CAT;
                    end
                end
                default: ;
            endcase
        end
        if (exit_go) begin
            st_nxt = ST_CATX;
        end
        // calibration pattern onto the data pins
        if (adr_fire && (st_r == ST_CAT)) begin
            dq_nxt = DQ_W'(ca_cal);                     // [R4]
            oe_nxt = 1'b1;                              // [R4]
        end
        // hold data through the exit delay, then release
        if (mrz_fire) begin
            oe_nxt = 1'b0;                              // [R8]
            st_nxt = ST_IDLE;
        end
        // write leveling: sample clock on strobe rise, return it later
        if (wl_edge) begin
            smp_nxt = ck_level;
        end
        if (wlo_fire && mr2_r[WRLVL_BIT]) begin
            dq_nxt = {DQ_W{smp_r}};                     // [R9]
            oe_nxt = 1'b1;                              // [R9]
        end
        if (st_r == ST_IDLE && !mr2_r[WRLVL_BIT] && !wlo_fire) begin
            oe_nxt = 1'b0;
        end
        // power-down style entry on cke outside training, exit on cke rise in any state
        if (cke_r && !cke && st_r == ST_IDLE) begin
            lp_nxt = 1'b1;
        end else if (!cke_r && cke) begin
            lp_nxt = 1'b0;
        end
        // termination follows the pin, forced off in low power
        if (rtt_go) begin
            tgt_nxt = rtt_want;
        end
        if (rtt_fire) begin
            rtt_nxt = tgt_r;                            // [R11] [R12] [R13]
        end
    end

    // registers only
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r  <= ST_IDLE;
            mr1_r <= MR1_DEF;
            mr2_r <= MR2_DEF;
            mr3_r <= MR3_DEF;
            dq_r  <= '0;
            oe_r  <= 1'b0;
            cke_r <= 1'b0;
            dqs_r <= 1'b0;
            lp_r  <= 1'b0;
            smp_r <= 1'b0;
            tgt_r <= 1'b0;
            rtt_r <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            mr1_r <= mr1_nxt;
            mr2_r <= mr2_nxt;
            mr3_r <= mr3_nxt;
            dq_r  <= dq_nxt;
            oe_r  <= oe_nxt;
            cke_r <= cke_nxt;
            dqs_r <= dqs_nxt;
            lp_r  <= lp_nxt;
            smp_r <= smp_nxt;
            tgt_r <= tgt_nxt;
            rtt_r <= rtt_nxt;
        end
    end

    // outputs
    assign dq_o         = dq_r;
    assign dq_oe        = oe_r;
    assign rtt_en       = rtt_r;
    assign train_active = (st_r != ST_IDLE);
    assign wrlvl_active = mr2_r[WRLVL_BIT];
    assign low_power    = lp_r;
    assign mr_cfg       = {mr3_r, mr2_r, mr1_r};

    ////////////////////////////////////////////////////////////////////////
    // checks
    localparam int A_ADR  = ADR_CYC + 1;
    localparam int A_MRZ  = MRZ_CYC + 1;
    localparam int A_WLO  = WLO_CYC + 1;
    localparam int A_RTT  = RTT_CYC + 1;
    localparam int D_WLO  = WLO_CYC;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_r4_cal;
        cal_go |-> ##A_ADR (dq_oe && dq_o[CA_W-1:0] == $past(ca_cal, A_ADR));
    endproperty
    a_r4_cal: assert property (p_r4_cal) // [R4]
        else $error("calibration result late or wrong");

    property p_r8_hold;
        (exit_go && dq_oe) |=> dq_oe;
    endproperty
    a_r8_hold: assert property (p_r8_hold) // [R8]
        else $error("data released too early after exit");

    property p_r8_rel;
        exit_go |-> ##[1:A_MRZ] (!dq_oe && !train_active);
    endproperty
    a_r8_rel: assert property (p_r8_rel) // [R8]
        else $error("data not released after exit");

    property p_r9_wl;
        (wl_edge ##1 mr2_r[WRLVL_BIT])
            |-> ##D_WLO (dq_oe && dq_o[0] == $past(ck_level, A_WLO));
    endproperty
    a_r9_wl: assert property (p_r9_wl) // [R9]
        else $error("leveling feedback late or wrong");

    property p_r11_on;
        (odt && !low_power) [*3] |-> rtt_en;
    endproperty
    a_r11_on: assert property (p_r11_on) // [R11]
        else $error("termination not switched on");

    property p_r11_off;
        (!odt) [*3] |-> !rtt_en;
    endproperty
    a_r11_off: assert property (p_r11_off) // [R11]
        else $error("termination not switched off");

    property p_r12_lp;
        $rose(low_power) |-> ##[1:A_RTT] !rtt_en;
    endproperty
    a_r12_lp: assert property (p_r12_lp) // [R12]
        else $error("termination still on in low power");

    property p_r13_exit;
        ($fell(low_power) ##0 odt [*3]) |-> rtt_en;
    endproperty
    a_r13_exit: assert property (p_r13_exit) // [R13]
        else $error("termination not restored after exit");

    property p_r17_rst;
        (is_mrw && mr_addr == MRA_RESET) |=> (mr_cfg[7:0] == MR1_DEF
            && mr_cfg[15:8] == MR2_DEF
            && mr_cfg[23:16] == $past(mr_cfg[23:16]));
    endproperty
    a_r17_rst: assert property (p_r17_rst) // [R17]
        else $error("reset write did not load defaults");

endmodule

// ---- src/lp3t_pkg.sv ----
package lp3t_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing figures, in picoseconds
    localparam int T_CLK_PS      = 25000;   // mclk period, 40 MHz
    localparam int T_ADR_MAX_PS  = 20000;   // command to calibration data
    localparam int T_MRZ_MIN_PS  = 3000;    // exit write to data release
    localparam int T_WLO_MAX_PS  = 20000;   // strobe edge to leveling data
    localparam int T_ODT_MIN_PS  = 1750;    // termination pin to switch
    localparam int T_ODT_MAX_PS  = 3500;
    localparam int T_ODTD_MAX_PS = 12000;   // low power entry to off
    localparam int T_ODTE_MAX_PS = 12000;   // low power exit to on

    // least times round up, longest times round down, never below one
    function automatic int cyc_least(input int ps);
        int c;
        c = (ps + T_CLK_PS - 1) / T_CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cyc_most(input int ps);
        int c;
        c = ps / T_CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int ADR_CYC  = cyc_most(T_ADR_MAX_PS);
    localparam int MRZ_CYC  = cyc_least(T_MRZ_MIN_PS);
    localparam int WLO_CYC  = cyc_most(T_WLO_MAX_PS);
    localparam int ODT_CYC  = cyc_most(T_ODT_MAX_PS);
    localparam int ODTD_CYC = cyc_most(T_ODTD_MAX_PS);
    localparam int ODTE_CYC = cyc_most(T_ODTE_MAX_PS);
    localparam int RTT_CYC0 = (ODTD_CYC < ODTE_CYC) ? ODTD_CYC : ODTE_CYC;
    localparam int RTT_CYC  = (ODT_CYC < RTT_CYC0) ? ODT_CYC : RTT_CYC0;

    ////////////////////////////////////////////////////////////////////////
    // command and mode register map
    typedef enum logic [1:0] {
        CMD_NOP   = 2'h0,
        CMD_MRW   = 2'h1,
        CMD_CAL   = 2'h2,
        CMD_OTHER = 2'h3
    } lp3t_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_CAT   = 2'h1,
        ST_CATX  = 2'h2
    } lp3t_state_t;

    localparam logic [7:0] MRA_CFG1      = 8'h01;
    localparam logic [7:0] MRA_CFG2      = 8'h02;
    localparam logic [7:0] MRA_CFG3      = 8'h03;
    localparam logic [7:0] MRA_RESET     = 8'h3F;
    localparam logic [7:0] MRA_CAT_ENTRY = 8'h29;
    localparam logic [7:0] MRA_CAT_EXIT  = 8'h2A;
    localparam logic [7:0] MR1_DEF       = 8'h03;
    localparam logic [7:0] MR2_DEF       = 8'h01;
    localparam logic [7:0] MR3_DEF       = 8'h02;
    localparam int         WRLVL_BIT     = 7;    // leveling enable in cfg2
    localparam int         CA_W          = 10;
    localparam int         MR_W          = 8;

endpackage

// ---- src/lp3t_dly.sv ----
`timescale 1ns/100ps
module lp3t_dly #(
    parameter int CYC = 1
) (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic start,
    output logic      fire
);
    localparam int W = $clog2(CYC + 1) + 1;
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    // reload on start, count down to the firing cycle
    always_comb begin
        cnt_nxt = cnt_r;
        if (start) begin
            cnt_nxt = W'(CYC);
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign fire = (cnt_r == W'(1));
endmodule

// ---- sim/lp3t_ctl.sv ----
`timescale 1ns/100ps
// controller side model, all counts kept in whole mclk cycles
// no row traffic is issued, so derated row times never apply
module lp3t_ctl (
    input  wire logic                      mclk,
    output logic                           cke,
    output lp3t_pkg::lp3t_cmd_t            cmd,
    output logic [7:0]                     mr_addr,
    output logic [lp3t_pkg::MR_W-1:0]      mr_data,
    output logic [lp3t_pkg::CA_W-1:0]      ca_cal,
    output logic                           dqs,
    output logic                           ck_level,
    output logic                           odt
);
    import lp3t_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // idle levels at time zero, strobe stands still low
    initial begin
        cke = 1'b1;
        cmd = CMD_NOP;
        mr_addr = 8'h00;
        mr_data = 8'h00;
        ca_cal = 10'h000;
        dqs = 1'b0;
        ck_level = 1'b0;
        odt = 1'b0;
    end

    // spacing waits, unused pins wander
    task idle(input int n);
        repeat (n) begin
            @(posedge mclk);
            mr_addr  <= 8'($urandom);
            mr_data  <= 8'($urandom);
            ca_cal   <= 10'($urandom);
            ck_level <= 1'($urandom);
        end
    endtask

    // one write, then bus shows the inverse once released
    task mrw(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        cmd <= CMD_MRW;
        mr_addr <= a;
        mr_data <= d;
        @(posedge mclk);
        cmd <= CMD_NOP;
        mr_addr <= ~a;
        mr_data <= ~d;
    endtask

    // pattern held one cycle past the command, then scrambled
    task cal(input logic [9:0] p);
        @(posedge mclk);
        cmd <= CMD_CAL;
        ca_cal <= p;
        @(posedge mclk);
        cmd <= CMD_NOP;
        @(posedge mclk);
        ca_cal <= ~p;
    endtask

    task set_cke(input logic v);
        @(posedge mclk);
        cke <= v;
    endtask

    task set_odt(input logic v);
        @(posedge mclk);
        odt <= v;
    endtask

    // one strobe pulse carrying a clock level sample
    task strobe(input logic lvl);
        @(posedge mclk);
        dqs <= 1'b1;
        ck_level <= lvl;
        @(posedge mclk);
        ck_level <= ~lvl;
        @(posedge mclk);
        dqs <= 1'b0;
    endtask
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/100ps
module tb;
    import lp3t_pkg::*;

    logic              mclk = 1'b0;
    logic              srst = 1'b1;
    logic              cke;
    lp3t_cmd_t         cmd;
    logic [7:0]        mr_addr;
    logic [MR_W-1:0]   mr_data;
    logic [CA_W-1:0]   ca_cal;
    logic              dqs;
    logic              ck_level;
    logic              odt;
    logic [31:0]       dq_o;
    logic              dq_oe;
    logic              rtt_en;
    logic              train_active;
    logic              wrlvl_active;
    logic              low_power;
    logic [23:0]       mr_cfg;
    int                n_fail = 0;
    int                comparisons = 0;
    int                mr[3] = '{3, 1, 2};
    int                i;
    logic [9:0]        pat;
    logic [9:0]        cal_q[$];
    logic              b;

    ////////////////////////////////////////////////////////////////////////
    // clock, partner and design
    always #12.5 mclk = ~mclk;

    lp3t_ctl i_lp3t_ctl (.mclk(mclk), .cke(cke), .cmd(cmd),
        .mr_addr(mr_addr), .mr_data(mr_data), .ca_cal(ca_cal), .dqs(dqs),
        .ck_level(ck_level), .odt(odt));

    lp3t_top i_lp3t_top (.mclk(mclk), .srst(srst), .cke(cke), .cmd(cmd),
        .mr_addr(mr_addr), .mr_data(mr_data), .ca_cal(ca_cal), .dqs(dqs),
        .ck_level(ck_level), .odt(odt), .dq_o(dq_o), .dq_oe(dq_oe),
        .rtt_en(rtt_en), .train_active(train_active),
        .wrlvl_active(wrlvl_active), .low_power(low_power),
        .mr_cfg(mr_cfg));

    ////////////////////////////////////////////////////////////////////////
    // compare, tick and closing
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] cfg_exp();
        return {8'h00, mr[2][7:0], mr[1][7:0], mr[0][7:0]};
    endfunction

    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task give_verdict;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // watchdog well past the expected hundred and sixty cycles
    initial begin
        #75000;
        n_fail++;
        give_verdict;
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        i = $urandom(2635);
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        #1;
        chk({8'h00, mr_cfg}, cfg_exp());
        chk(32'(dq_oe), 32'h0);
        // address training: entry, calibrations, exit
        i_lp3t_ctl.mrw(MRA_CAT_ENTRY, 8'($urandom));
        tick(1);
        chk(32'(train_active), 32'h1);
        i_lp3t_ctl.idle(10);
        i_lp3t_ctl.set_cke(1'b0);
        i_lp3t_ctl.idle(10);
        for (i = 0; i < 4; i++) begin
            pat = (i < 2) ? {10{i[0]}} : 10'($urandom);
            cal_q.push_back(pat);
            i_lp3t_ctl.cal(pat);
            tick(1);
            chk(32'(dq_oe), 32'h1);
            chk(dq_o, 32'(cal_q.pop_front()));
        end
        i_lp3t_ctl.idle(10);
        i_lp3t_ctl.set_cke(1'b1);
        i_lp3t_ctl.idle(10);
        i_lp3t_ctl.mrw(MRA_CAT_EXIT, 8'($urandom));
        #1;
        chk(32'(dq_oe), 32'h1);
        tick(1);
        chk(32'(dq_oe), 32'h0);
        chk(32'(train_active), 32'h0);
        i_lp3t_ctl.cal(10'h155);
        tick(1);
        chk(32'(dq_oe), 32'h0);
        // write leveling feedback
        i_lp3t_ctl.mrw(MRA_CFG2, 8'h80);
        mr[1] = 8'h80;
        i_lp3t_ctl.idle(25);
        for (i = 0; i < 4; i++) begin
            b = i[0] ^ 1'($urandom);
            i_lp3t_ctl.strobe(b);
            tick(1);
            chk(dq_o, {32{b}});
            chk(32'(dq_oe), 32'h1);
            chk(32'(wrlvl_active), 32'h1);
        end
        i_lp3t_ctl.mrw(MRA_CFG2, 8'h00);
        mr[1] = 0;
        tick(2);
        chk(32'(dq_oe), 32'h0);
        chk(32'(wrlvl_active), 32'h0);
        // termination pin follows
        for (i = 0; i < 4; i++) begin
            b = ~i[0];
            i_lp3t_ctl.set_odt(b);
            tick(3);
            chk(32'(rtt_en), 32'(b));
        end
        // low power entry and exit with termination requested
        i_lp3t_ctl.set_odt(1'b1);
        i_lp3t_ctl.set_cke(1'b0);
        tick(2);
        chk(32'(low_power), 32'h1);
        tick(2);
        chk(32'(rtt_en), 32'h0);
        i_lp3t_ctl.set_cke(1'b1);
        tick(2);
        chk(32'(low_power), 32'h0);
        tick(2);
        chk(32'(rtt_en), 32'h1);
        // config writes then reset command
        for (i = 0; i < 3; i++) begin
            mr[i] = $urandom & 8'h7F;
            i_lp3t_ctl.mrw(8'(MRA_CFG1 + i), 8'(mr[i]));
        end
        tick(1);
        chk({8'h00, mr_cfg}, cfg_exp());
        i_lp3t_ctl.mrw(MRA_RESET, 8'($urandom));
        mr[0] = 3;
        mr[1] = 1;
        tick(1);
        chk({8'h00, mr_cfg}, cfg_exp());
        give_verdict;
    end
endmodule
